//--- src/cpu_decode_params.svh
/*
 Named constants of the opcode decoder: opcodes, map columns and rows,
 legality masks, cycle counts and operand byte counts.
 Assumes it is included once per compile unit by its bare name.
*/
`ifndef CPU_DECODE_PARAMS_SVH
`define CPU_DECODE_PARAMS_SVH
// Opcodes with their own behaviour
`define OPC_TO_ACC 8'h9F
`define OPC_WAIT_IRQ 8'h8F
`define OPC_MUL 8'h42
`define OPC_BSR 8'hAD
`define OPC_RTI 8'h80
`define OPC_RTS 8'h81
`define OPC_SWI 8'h83
`define OPC_TAX 8'h97
`define OPC_NOP 8'h9D
// Map columns (upper nibble)
`define COL_BRBIT 4'h0
`define COL_BITMOD 4'h1
`define COL_REL 4'h2
`define COL_RMW_DIR 4'h3
`define COL_RMW_A 4'h4
`define COL_RMW_X 4'h5
`define COL_RMW_OFS8 4'h6
`define COL_RMW_PTR 4'h7
`define COL_CTRL 4'h8
`define COL_REGOP 4'h9
`define COL_LITERAL 4'hA
`define COL_DIR 4'hB
`define COL_LONG 4'hC
`define COL_OFS16 4'hD
`define COL_OFS8 4'hE
`define COL_PTR 4'hF
// Map rows (lower nibble) with cycle adjustments
`define ROW_STORE 4'h7
`define ROW_STX 4'hF
`define ROW_JMP 4'hC
`define ROW_JSR 4'hD
`define ROW_TEST 4'hD
// Legal rows (CTRL, REGOP) or hole rows (RMW, LITERAL) per column group, bit n = row n
`define RMW_HOLE_MASK 16'h4826
`define CTRL_LEGAL_MASK 16'hC00B
`define REGOP_LEGAL_MASK 16'hBF80
`define LITERAL_HOLE_MASK 16'h9080
// Execution cycles
`define CYC_BRBIT 4'h5
`define CYC_BITMOD 4'h5
`define CYC_REL 4'h3
`define CYC_RMW_DIR 4'h5
`define CYC_RMW_REG 4'h3
`define CYC_RMW_OFS8 4'h6
`define CYC_RMW_PTR 4'h5
`define CYC_MUL 4'hB
`define CYC_RTI 4'h9
`define CYC_RTS 4'h6
`define CYC_SWI 4'hA
`define CYC_SHORT 4'h2
`define CYC_LITERAL 4'h2
`define CYC_DIR 4'h3
`define CYC_LONG 4'h4
`define CYC_OFS16 4'h5
`define CYC_OFS8 4'h4
`define CYC_PTR 4'h3
`define CYC_BSR 4'h6
`define CYC_ONE 4'h1
`define CYC_JSR_MORE 4'h2
// Instruction lengths and operand gathering
`define LEN_ONE 2'h1
`define LEN_TWO 2'h2
`define LEN_THREE 2'h3
`define GATHER_NONE 2'h0
`define GATHER_LAST 2'h1
`define GATHER_STEP 2'h1
`define ZERO_PAGE 8'h00
`endif

//--- src/cpu_decode_pkg.sv
/*
 Types of the opcode decoder: instruction groups, addressing modes,
 the decoded instruction record and the operand byte pair.
 Assumes nothing of its surroundings.
*/
package cpu_decode_pkg;
	typedef enum logic [2:0] {
		GRP_BITBRANCH,
		GRP_BITMOD,
		GRP_BRANCH,
		GRP_RMW,
		GRP_CTRL,
		GRP_REGMEM
	} group_e;
	typedef enum logic [2:0] {
		IMPLIED_MODE,
		LITERAL_OPERAND_MODE,
		DIRECT_MODE,
		RELATIVE_MODE,
		LONG_ADDRESS_MODE,
		REG_POINTER_MODE,
		SHORT_OFFSET_POINTER_MODE,
		LONG_OFFSET_POINTER_MODE
	} addr_mode_e;
	typedef struct packed {
		logic [7:0] first;
		logic [7:0] second;
	} operand_pair_s;
	typedef struct packed {
		logic [7:0] opcode;
		group_e group;
		addr_mode_e mode;
		logic [1:0] length;
		logic [3:0] cycles;
		logic illegal;
		logic [15:0] effAddr;
		logic [7:0] literal;
		logic [15:0] target;
		logic [2:0] bitNum;
		logic bitHigh;
		logic keepAllFlags;
		logic clearIntMask;
		logic haltCpuClock;
		logic moveIndexToAcc;
	} decode_s;
endpackage

//--- src/cpu_operand_gather.sv
/*
 Collects up to two operand bytes that follow an opcode, first byte first.
 Assumes the byte source holds byteValid and byteIn until byteReady is seen.
*/
`include "cpu_decode_params.svh"
module cpu_operand_gather import cpu_decode_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [1:0] needCount,
	input wire logic byteValid,
	input wire logic [7:0] byteIn,
	output logic byteReady,
	output logic done,
	output operand_pair_s operands
);
	logic [1:0] left_reg;
	logic slot_reg;
	operand_pair_s bytes_reg;
	logic take;

	// Ready only while bytes are owed, so no byte is swallowed twice
	assign byteReady = (left_reg != `GATHER_NONE);
	assign take = byteReady & byteValid;
	assign done = take & (left_reg == `GATHER_LAST);
	assign operands = bytes_reg;

	// Byte counter and slot select
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			left_reg <= `GATHER_NONE;
			slot_reg <= 1'b0;
			bytes_reg <= '0;
		end else if (start) begin
			left_reg <= needCount;
			slot_reg <= 1'b0;
		end else if (take) begin
			left_reg <= left_reg - `GATHER_STEP;
			slot_reg <= 1'b1;
			if (slot_reg) begin
				bytes_reg.second <= byteIn;
			end else begin
				bytes_reg.first <= byteIn;
			end
		end
	end
endmodule

//--- src/cpu_opcode_decode.sv
/*
 One-byte opcode decoder of an 8-bit accumulator core: takes the opcode and
 its operand bytes from program memory and issues one decoded record.
 Assumes the fetch side gives the opcode's address with the opcode byte and
 that indexReg is stable while an instruction is being gathered.
*/
// Notes on behaviour
// - The upper opcode nibble picks the map column, fixing group and, except for BSR, addressing mode.
// - The lower opcode nibble picks the map row, fixing the operation within the column.
// - Opcode 9F copies the index register to the accumulator, inherent, 2 cycles, flags untouched.
// - Opcode 8F clears the interrupt mask and halts the CPU clock until an interrupt, one byte.
// - Every opcode yields its cycle count, operation, byte length and addressing mode.
// - In direct mode the byte after the opcode is the operand address.
// - In immediate mode the byte after the opcode is the operand, in its own column.
// - Bit test and branch reads a direct address byte then a displacement, three bytes.
// - In extended mode two bytes, high first, form the operand address.
// - With a 16-bit offset, two bytes high first are added to the index register.
// - With an 8-bit offset, one byte is added to the index register.
// - With no offset the index register alone is the address and the instruction is one byte.
// - Relative branches carry one displacement byte applied when taken.
`include "cpu_decode_params.svh"
module cpu_opcode_decode import cpu_decode_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic fetchValid,
	input wire logic [7:0] fetchByte,
	input wire logic [15:0] opcodeAddr,
	input wire logic [7:0] indexReg,
	output logic fetchReady,
	output logic decValid,
	output decode_s decInfo
);
	typedef enum {S_IDLE, S_GATHER, S_ISSUE} state_e;

	function automatic group_e groupOf(input logic [3:0] col);
		case (col)
			`COL_BRBIT: groupOf = GRP_BITBRANCH;
			`COL_BITMOD: groupOf = GRP_BITMOD;
			`COL_REL: groupOf = GRP_BRANCH;
			`COL_RMW_DIR, `COL_RMW_A, `COL_RMW_X, `COL_RMW_OFS8, `COL_RMW_PTR: groupOf = GRP_RMW;
			`COL_CTRL, `COL_REGOP: groupOf = GRP_CTRL;
			default: groupOf = GRP_REGMEM;
		endcase
	endfunction

	// column to mode; BSR is the one relative entry of the literal column
	function automatic addr_mode_e modeOf(input logic [7:0] opc);
		case (opc[7:4])
			`COL_BRBIT, `COL_BITMOD, `COL_RMW_DIR, `COL_DIR: modeOf = DIRECT_MODE;
			`COL_REL: modeOf = RELATIVE_MODE;
			`COL_RMW_OFS8, `COL_OFS8: modeOf = SHORT_OFFSET_POINTER_MODE;
			`COL_RMW_PTR, `COL_PTR: modeOf = REG_POINTER_MODE;
			`COL_LITERAL: modeOf = (opc == `OPC_BSR) ? RELATIVE_MODE : LITERAL_OPERAND_MODE;
			`COL_LONG: modeOf = LONG_ADDRESS_MODE;
			`COL_OFS16: modeOf = LONG_OFFSET_POINTER_MODE;
			default: modeOf = IMPLIED_MODE;
		endcase
	endfunction

	// byte length from mode; bit test and branch adds its displacement
	function automatic logic [1:0] lenOf(input logic [7:0] opc);
		case (modeOf(opc))
			IMPLIED_MODE, REG_POINTER_MODE: lenOf = `LEN_ONE;
			LONG_ADDRESS_MODE, LONG_OFFSET_POINTER_MODE: lenOf = `LEN_THREE;
			default: lenOf = (opc[7:4] == `COL_BRBIT) ? `LEN_THREE : `LEN_TWO;
		endcase
	endfunction

	// cycle count per column, then per row
	function automatic logic [3:0] cyclesOf(input logic [7:0] opc);
		logic [3:0] base;
		logic isTest;
		base = `CYC_PTR;
		isTest = (opc[3:0] == `ROW_TEST);
		case (opc[7:4])
			`COL_BRBIT: cyclesOf = `CYC_BRBIT;
			`COL_BITMOD: cyclesOf = `CYC_BITMOD;
			`COL_REL: cyclesOf = `CYC_REL;
			`COL_RMW_DIR: cyclesOf = isTest ? `CYC_RMW_DIR - `CYC_ONE : `CYC_RMW_DIR;
			`COL_RMW_A, `COL_RMW_X: cyclesOf = (opc == `OPC_MUL) ? `CYC_MUL : `CYC_RMW_REG;
			`COL_RMW_OFS8: cyclesOf = isTest ? `CYC_RMW_OFS8 - `CYC_ONE : `CYC_RMW_OFS8;
			`COL_RMW_PTR: cyclesOf = isTest ? `CYC_RMW_PTR - `CYC_ONE : `CYC_RMW_PTR;
			`COL_CTRL: begin
				if (opc == `OPC_RTI) cyclesOf = `CYC_RTI;
				else if (opc == `OPC_RTS) cyclesOf = `CYC_RTS;
				else if (opc == `OPC_SWI) cyclesOf = `CYC_SWI;
				else cyclesOf = `CYC_SHORT;
			end
			`COL_REGOP: cyclesOf = `CYC_SHORT;
			default: begin
				case (opc[7:4])
					`COL_LITERAL: base = `CYC_LITERAL;
					`COL_DIR: base = `CYC_DIR;
					`COL_LONG: base = `CYC_LONG;
					`COL_OFS16: base = `CYC_OFS16;
					`COL_OFS8: base = `CYC_OFS8;
					default: base = `CYC_PTR;
				endcase
				if (opc == `OPC_BSR) cyclesOf = `CYC_BSR;
				else if (opc[3:0] == `ROW_STORE || opc[3:0] == `ROW_STX) cyclesOf = base + `CYC_ONE;
				else if (opc[3:0] == `ROW_JMP) cyclesOf = base - `CYC_ONE;
				else if (opc[3:0] == `ROW_JSR) cyclesOf = base + `CYC_JSR_MORE;
				else cyclesOf = base;
			end
		endcase
	endfunction

	// row legality within each column
	// Masks held in variables, since a literal cannot be bit-selected
	function automatic logic legalOf(input logic [7:0] opc);
		logic [15:0] rmwHoles;
		logic [15:0] ctrlLegal;
		logic [15:0] regopLegal;
		logic [15:0] literalHoles;
		rmwHoles = `RMW_HOLE_MASK;
		ctrlLegal = `CTRL_LEGAL_MASK;
		regopLegal = `REGOP_LEGAL_MASK;
		literalHoles = `LITERAL_HOLE_MASK;
		case (groupOf(opc[7:4]))
			GRP_RMW: legalOf = !rmwHoles[opc[3:0]] || (opc == `OPC_MUL);
			GRP_CTRL: legalOf = (opc[7:4] == `COL_CTRL) ? ctrlLegal[opc[3:0]] : regopLegal[opc[3:0]];
			GRP_REGMEM: legalOf = (opc[7:4] != `COL_LITERAL) || !literalHoles[opc[3:0]];
			default: legalOf = 1'b1;
		endcase
	endfunction

	// signed displacement from the next instruction's address
	function automatic logic [15:0] relTarget(input logic [15:0] pc, input logic [1:0] len,
		input logic [7:0] disp);
		relTarget = pc + {14'h0000, len} + {{8{disp[7]}}, disp};
	endfunction

	state_e state_reg, state_next;
	logic [7:0] opcode_reg;
	logic [15:0] pc_reg;
	logic decValid_reg;
	decode_s decInfo_reg, info;
	logic opcodeTake, gatherStart, gatherReady, gatherDone;
	logic [1:0] needNow;
	operand_pair_s operands;
	addr_mode_e modeNow;
	logic [15:0] xWide, longAddr, shortAddr;
	logic [7:0] dispNow;

	// Opcode taken only when idle; operand bytes go to the gatherer
	assign opcodeTake = (state_reg == S_IDLE) & fetchValid;
	assign needNow = lenOf(fetchByte) - `LEN_ONE;
	assign gatherStart = opcodeTake & (needNow != `GATHER_NONE);
	assign fetchReady = (state_reg == S_IDLE) | gatherReady;

	cpu_operand_gather u_gather (
		.ref_clk(ref_clk),
		.rst(rst),
		.start(gatherStart),
		.needCount(needNow),
		.byteValid(fetchValid),
		.byteIn(fetchByte),
		.byteReady(gatherReady),
		.done(gatherDone),
		.operands(operands)
	);

	// Sequencing: one-byte opcodes skip gathering
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			S_IDLE: if (opcodeTake) state_next = gatherStart ? S_GATHER : S_ISSUE;
			S_GATHER: if (gatherDone) state_next = S_ISSUE;
			S_ISSUE: state_next = S_IDLE;
			default: state_next = S_IDLE;
		endcase
	end

	// Address forming from the gathered bytes
	assign modeNow = modeOf(opcode_reg);
	assign xWide = {`ZERO_PAGE, indexReg};
	assign longAddr = {operands.first, operands.second};
	assign shortAddr = {`ZERO_PAGE, operands.first};
	// bit branch displacement is the second byte
	assign dispNow = (opcode_reg[7:4] == `COL_BRBIT) ? operands.second : operands.first;

	// Decoded record
	always_comb begin
		info = '0;
		info.opcode = opcode_reg;
		info.group = groupOf(opcode_reg[7:4]);
		info.mode = modeNow;
		info.length = lenOf(opcode_reg);
		info.cycles = cyclesOf(opcode_reg);
		info.illegal = !legalOf(opcode_reg);
		case (modeNow)
			DIRECT_MODE: info.effAddr = shortAddr;
			LONG_ADDRESS_MODE: info.effAddr = longAddr;
			LONG_OFFSET_POINTER_MODE: info.effAddr = longAddr + xWide;
			SHORT_OFFSET_POINTER_MODE: info.effAddr = shortAddr + xWide;
			REG_POINTER_MODE: info.effAddr = xWide;
			default: info.effAddr = '0;
		endcase
		// literal operand straight from the stream
		info.literal = (modeNow == LITERAL_OPERAND_MODE) ? operands.first : `ZERO_PAGE;
		if (modeNow == RELATIVE_MODE || info.group == GRP_BITBRANCH) begin
			info.target = relTarget(pc_reg, info.length, dispNow);
		end
		info.bitNum = opcode_reg[3:1];
		info.bitHigh = !opcode_reg[0];
		info.moveIndexToAcc = (opcode_reg == `OPC_TO_ACC);
		info.keepAllFlags = info.moveIndexToAcc || opcode_reg == `OPC_TAX || opcode_reg == `OPC_NOP
			|| info.group == GRP_BRANCH || opcode_reg == `OPC_BSR;
		// wait clears the mask and halts the clock
		info.clearIntMask = (opcode_reg == `OPC_WAIT_IRQ);
		info.haltCpuClock = (opcode_reg == `OPC_WAIT_IRQ);
	end

	// State and issue registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= S_IDLE;
			opcode_reg <= `ZERO_PAGE;
			pc_reg <= '0;
			decValid_reg <= 1'b0;
			decInfo_reg <= '0;
		end else begin
			state_reg <= state_next;
			decValid_reg <= (state_reg == S_ISSUE);
			if (opcodeTake) begin
				opcode_reg <= fetchByte;
				pc_reg <= opcodeAddr;
			end
			if (state_reg == S_ISSUE) decInfo_reg <= info;
		end
	end

	assign decValid = decValid_reg;
	assign decInfo = decInfo_reg;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	property p_colGroup;
		decValid |-> (decInfo.group == GRP_RMW) == (decInfo.opcode[7:4] >= `COL_RMW_DIR
			&& decInfo.opcode[7:4] <= `COL_RMW_PTR) && (decInfo.group == GRP_BRANCH) == (decInfo.opcode[7:4] == `COL_REL);
	endproperty
	a_colGroup: assert property (p_colGroup) else $error("group not from upper nibble");
	property p_rowKept;
		(opcodeTake && needNow == `GATHER_NONE) || gatherDone |-> ##2 decValid
			&& decInfo.opcode[3:0] == $past(opcode_reg[3:0]);
	endproperty
	a_rowKept: assert property (p_rowKept) else $error("row lost or issue late");
	property p_toAcc;
		decValid && decInfo.opcode == `OPC_TO_ACC |-> decInfo.moveIndexToAcc && decInfo.keepAllFlags
			&& decInfo.cycles == 4'h2 && decInfo.mode == IMPLIED_MODE;
	endproperty
	a_toAcc: assert property (p_toAcc) else $error("index copy decoded wrong");
	property p_waitIrq;
		opcodeTake && fetchByte == `OPC_WAIT_IRQ |-> ##2 decValid && decInfo.haltCpuClock
			&& decInfo.clearIntMask && decInfo.length == 2'h1;
	endproperty
	a_waitIrq: assert property (p_waitIrq) else $error("wait decoded wrong");
	property p_oneByte;
		opcodeTake && needNow == 2'h0 |-> ##1 !fetchReady ##1 decValid;
	endproperty
	a_oneByte: assert property (p_oneByte) else $error("one-byte issue timing wrong");
	property p_direct;
		decValid && decInfo.mode == DIRECT_MODE |-> decInfo.effAddr == {8'h00, operands.first};
	endproperty
	a_direct: assert property (p_direct) else $error("direct address wrong");
	property p_literal;
		decValid && decInfo.opcode[7:4] == 4'hA && decInfo.opcode != 8'hAD
			|-> decInfo.literal == operands.first && decInfo.length == 2'h2;
	endproperty
	a_literal: assert property (p_literal) else $error("literal operand wrong");
	property p_bitBranch;
		decValid && decInfo.group == GRP_BITBRANCH |-> decInfo.length == 2'h3
			&& decInfo.target == pc_reg + 16'h0003 + {{8{operands.second[7]}}, operands.second};
	endproperty
	a_bitBranch: assert property (p_bitBranch) else $error("bit branch decoded wrong");
	property p_extended;
		decValid && decInfo.mode == LONG_ADDRESS_MODE |-> decInfo.effAddr[15:8] == operands.first;
	endproperty
	a_extended: assert property (p_extended) else $error("extended high byte wrong");
	property p_offset16;
		decValid && decInfo.mode == LONG_OFFSET_POINTER_MODE
			|-> decInfo.effAddr - {8'h00, indexReg} == {operands.first, operands.second};
	endproperty
	a_offset16: assert property (p_offset16) else $error("16-bit offset address wrong");
	property p_offset8;
		decValid && decInfo.mode == SHORT_OFFSET_POINTER_MODE
			|-> decInfo.effAddr == {8'h00, operands.first} + {8'h00, indexReg};
	endproperty
	a_offset8: assert property (p_offset8) else $error("8-bit offset address wrong");
	property p_noOffset;
		decValid && decInfo.mode == REG_POINTER_MODE |-> decInfo.length == 2'h1
			&& decInfo.effAddr == {8'h00, indexReg};
	endproperty
	a_noOffset: assert property (p_noOffset) else $error("index-only decode wrong");
	property p_relative;
		decValid && decInfo.group == GRP_BRANCH |-> decInfo.length == 2'h2
			&& decInfo.target == pc_reg + 16'h0002 + {{8{operands.first[7]}}, operands.first};
	endproperty
	a_relative: assert property (p_relative) else $error("branch target wrong");
	property p_bitPolarity;
		decValid && decInfo.group == GRP_BITMOD |-> decInfo.bitHigh != decInfo.opcode[0]
			&& decInfo.bitNum == decInfo.opcode[3:1];
	endproperty
	a_bitPolarity: assert property (p_bitPolarity) else $error("bit polarity wrong");

	c_extended: cover property (decValid && decInfo.mode == LONG_ADDRESS_MODE);
	c_bitBranch: cover property (decValid && decInfo.group == GRP_BITBRANCH);
	c_waitIrq: cover property (decValid && decInfo.haltCpuClock);
	c_backToBack: cover property (decValid && opcodeTake);
endmodule

//--- testbench/prog_mem_model.sv
/*
 Behavioural program memory standing on the fetch side of the decoder.
 Assumes the bench fills mem while the model is idle and pulses load.
*/
module prog_mem_model (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [15:0] loadAddr,
	input wire logic [15:0] endAddr,
	input wire logic slow,
	input wire logic fetchReady,
	output logic fetchValid,
	output logic [7:0] fetchByte,
	output logic [15:0] opcodeAddr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:1023];
	logic [15:0] pc_reg;
	logic gap_reg;
	wire logic taken = fetchValid && fetchReady;
	wire logic [15:0] pcNext = taken ? pc_reg + 16'h0001 : pc_reg;
	wire logic [7:0] cur = mem[pc_reg[9:0]];
	// Idle bus shows inverted data so stale bytes never pass as valid
	assign fetchByte = fetchValid ? cur : ~cur;
	assign opcodeAddr = fetchValid ? pc_reg : ~pc_reg;
	// Offer held until taken; slow mode leaves a gap between bytes
	always_ff @(posedge ref_clk) begin
		if (rst || load) begin
			pc_reg <= loadAddr;
			fetchValid <= 1'b0;
			gap_reg <= 1'b0;
		end else begin
			pc_reg <= pcNext;
			gap_reg <= ~gap_reg;
			if (!fetchValid || fetchReady) begin
				fetchValid <= (pcNext != endAddr) && (!slow || gap_reg);
			end
		end
	end
endmodule

//--- testbench/tb.sv
/*
 Self-checking bench of the opcode decoder, fed by the program memory model.
 Assumes the decoder contract of one record per instruction.
*/
module tb;
	import cpu_decode_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic load = 1'b0;
	logic slow = 1'b0;
	logic [15:0] loadAddr = 16'h0000;
	logic [15:0] endAddr = 16'h0000;
	logic [7:0] indexReg = 8'hF0;
	logic fetchValid, fetchReady, decValid;
	logic [7:0] fetchByte;
	logic [15:0] opcodeAddr;
	decode_s decInfo;
	decode_s recQ [$];
	int badCount = 0;
	int samplesChecked = 0;

	prog_mem_model mem_u (.ref_clk(ref_clk), .rst(rst), .load(load), .loadAddr(loadAddr), .endAddr(endAddr),
		.slow(slow), .fetchReady(fetchReady), .fetchValid(fetchValid), .fetchByte(fetchByte),
		.opcodeAddr(opcodeAddr));
	cpu_opcode_decode dut_u (.ref_clk(ref_clk), .rst(rst), .fetchValid(fetchValid), .fetchByte(fetchByte),
		.opcodeAddr(opcodeAddr), .indexReg(indexReg), .fetchReady(fetchReady), .decValid(decValid),
		.decInfo(decInfo));

	// Clock of 50 ns
	initial begin
		forever #25 ref_clk = ~ref_clk;
	end
	// Records collected as they are issued
	always @(posedge ref_clk) begin
		if (decValid === 1'b1) begin
			recQ.push_back(decInfo);
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			badCount++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic chk_rec(input decode_s r, input addr_mode_e m, input int l, input int c);
		chk(16'(r.mode), 16'(m));
		chk(16'(r.length), 16'(l));
		chk(16'(r.cycles), 16'(c));
	endtask

	task automatic place(input logic [15:0] a, input logic [7:0] b0, b1, b2);
		mem_u.mem[a[9:0]] = b0;
		mem_u.mem[a[9:0] + 10'h001] = b1;
		mem_u.mem[a[9:0] + 10'h002] = b2;
	endtask

	// Starts the model and waits, bounded, for n records
	task automatic go(input logic [15:0] a, e, input int n, output decode_s r);
		int w;
		recQ.delete();
		@(posedge ref_clk);
		loadAddr <= a;
		endAddr <= e;
		load <= 1'b1;
		@(posedge ref_clk);
		load <= 1'b0;
		for (w = 0; w < 200 && recQ.size() < n; w++) begin
			@(posedge ref_clk);
		end
		repeat (4) @(posedge ref_clk);
		chk(16'(recQ.size()), 16'(n));
		r = (recQ.size() > 0) ? recQ[0] : '0;
	endtask

	task automatic s_special();
		decode_s r;
		place(16'h0010, 8'h9F, 8'h8F, 8'h00);
		go(16'h0010, 16'h0011, 1, r);
		chk(16'(r.moveIndexToAcc), 16'h0001);
		chk(16'(r.keepAllFlags), 16'h0001);
		chk_rec(r, IMPLIED_MODE, 1, 2);
		go(16'h0011, 16'h0012, 1, r);
		chk(16'({r.clearIntMask, r.haltCpuClock, r.moveIndexToAcc}), 16'h0006);
		chk_rec(r, IMPLIED_MODE, 1, 2);
	endtask

	task automatic s_modes();
		logic [7:0] ops [11] = '{8'hA6, 8'hB6, 8'hC6, 8'hD6, 8'hE6, 8'hF6, 8'h30, 8'h40, 8'h50, 8'h60, 8'h70};
		addr_mode_e md [11] = '{LITERAL_OPERAND_MODE, DIRECT_MODE, LONG_ADDRESS_MODE, LONG_OFFSET_POINTER_MODE,
			SHORT_OFFSET_POINTER_MODE, REG_POINTER_MODE, DIRECT_MODE, IMPLIED_MODE, IMPLIED_MODE,
			SHORT_OFFSET_POINTER_MODE, REG_POINTER_MODE};
		int ln [11] = '{2, 2, 3, 3, 2, 1, 2, 1, 1, 2, 1};
		int cy [11] = '{2, 3, 4, 5, 4, 3, 5, 3, 3, 6, 5};
		logic [15:0] ea [11] = '{16'h0000, 16'h0012, 16'h1234, 16'h1324, 16'h0102, 16'h00F0, 16'h0012,
			16'h0000, 16'h0000, 16'h0102, 16'h00F0};
		decode_s r;
		// Second pass with a stalling memory
		for (int p = 0; p < 2; p++) begin
			slow <= p[0];
			for (int i = 0; i < 11; i++) begin
				place(16'h0300, ops[i], 8'h12, 8'h34);
				go(16'h0300, 16'h0300 + 16'(ln[i]), 1, r);
				chk(16'(r.opcode), 16'(ops[i]));
				chk(16'(r.group), 16'(i < 6 ? GRP_REGMEM : GRP_RMW));
				chk_rec(r, md[i], ln[i], cy[i]);
				if (md[i] != IMPLIED_MODE && md[i] != LITERAL_OPERAND_MODE) begin
					chk(r.effAddr, ea[i]);
				end
				if (i == 0) begin
					chk(16'(r.literal), 16'h0012);
				end
			end
		end
		slow <= 1'b0;
	endtask

	task automatic s_bits();
		logic [7:0] op;
		decode_s r;
		// Every row of both bit columns, negative displacement
		for (int i = 0; i < 32; i++) begin
			op = {3'h0, i[4], i[3:0]};
			place(16'h0200, op, 8'h55, 8'hF0);
			go(16'h0200, i[4] ? 16'h0202 : 16'h0203, 1, r);
			chk(16'(r.bitNum), 16'(i[3:1]));
			chk(16'(r.bitHigh), 16'(!i[0]));
			chk(r.effAddr, 16'h0055);
			chk_rec(r, DIRECT_MODE, i[4] ? 2 : 3, 5);
			if (!i[4]) begin
				chk(r.target, 16'h01F3);
			end
		end
	endtask

	task automatic s_branch();
		decode_s r;
		place(16'h0100, 8'h26, 8'h80, 8'h00);
		go(16'h0100, 16'h0102, 1, r);
		chk(r.target, 16'h0082);
		chk(16'(r.keepAllFlags), 16'h0001);
		chk_rec(r, RELATIVE_MODE, 2, 3);
		place(16'h0100, 8'h20, 8'h7F, 8'h00);
		go(16'h0100, 16'h0102, 1, r);
		chk(r.target, 16'h0181);
	endtask

	task automatic s_back_to_back();
		decode_s r;
		place(16'h0040, 8'h9F, 8'h8F, 8'hC6);
		place(16'h0043, 8'hAB, 8'hCD, 8'h9F);
		go(16'h0040, 16'h0046, 4, r);
		if (recQ.size() == 4) begin
			chk(16'(recQ[1].opcode), 16'h008F);
			chk(recQ[2].effAddr, 16'hABCD);
			chk(16'(recQ[3].moveIndexToAcc), 16'h0001);
		end
	endtask

	task automatic s_rows();
		logic [7:0] ops [12] = '{8'h42, 8'h80, 8'h81, 8'h83, 8'h82, 8'h41,
			8'h7D, 8'hBD, 8'hCC, 8'hB7, 8'hAD, 8'hA7};
		addr_mode_e md [12] = '{IMPLIED_MODE, IMPLIED_MODE, IMPLIED_MODE, IMPLIED_MODE, IMPLIED_MODE, IMPLIED_MODE,
			REG_POINTER_MODE, DIRECT_MODE, LONG_ADDRESS_MODE, DIRECT_MODE, RELATIVE_MODE, LITERAL_OPERAND_MODE};
		int ln [12] = '{1, 1, 1, 1, 1, 1, 1, 2, 3, 2, 2, 2};
		int cy [12] = '{11, 9, 6, 10, 2, 3, 4, 5, 3, 4, 6, 3};
		logic [11:0] illegalSet = 12'h830;
		decode_s r;
		// Row cycle adjustments, control entries and holes in the map
		for (int i = 0; i < 12; i++) begin
			place(16'h0300, ops[i], 8'h12, 8'h34);
			go(16'h0300, 16'h0300 + 16'(ln[i]), 1, r);
			chk(16'(r.illegal), 16'(illegalSet[i]));
			chk_rec(r, md[i], ln[i], cy[i]);
			if (i == 10) begin
				chk(r.target, 16'h0314);
			end
		end
	endtask

	task automatic testDone();
		$display("comparisons %0d mismatches %0d", samplesChecked, badCount);
		if (badCount == 0 && samplesChecked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Watchdog well beyond the thousand or so cycles the tests need
	initial begin
		repeat (30000) @(posedge ref_clk);
		badCount++;
		$display("watchdog expired");
		testDone();
	end

	initial begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		// Idle outputs on the first edge after release
		@(posedge ref_clk);
		chk(16'(decValid), 16'h0000);
		chk(16'(fetchReady), 16'h0001);
		s_special();
		s_modes();
		s_bits();
		s_branch();
		s_back_to_back();
		s_rows();
		testDone();
	end
endmodule
